//--- shared/cbsl_pkg.sv
package cbsl_pkg;
  // buffer counts
  localparam int NRX = 32;
  localparam int NTX = 8;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_FULL_LO = 8'h00;
  localparam logic [7:0] OFS_FULL_HI = 8'h04;
  localparam logic [7:0] OFS_OVF_LO  = 8'h08;
  localparam logic [7:0] OFS_OVF_HI  = 8'h0c;
  localparam logic [7:0] OFS_CON0    = 8'h10;
  localparam logic [7:0] OFS_CON1    = 8'h14;
  localparam logic [7:0] OFS_CON2    = 8'h18;
  localparam logic [7:0] OFS_CON3    = 8'h1c;
  // reset values
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [7:0]  RST_CON   = 8'h00;
  // buffer control byte fields
  localparam int CON_DIR   = 7;
  localparam int CON_ABT   = 6;
  localparam int CON_LARB  = 5;
  localparam int CON_ERR   = 4;
  localparam int CON_REQ   = 3;
  localparam int CON_RTREN = 2;
  localparam int CON_PRI_H = 1;
  localparam int CON_PRI_L = 0;
  // message buffer word layout
  localparam int W0_SID_H  = 12;
  localparam int W0_SID_L  = 2;
  localparam int W0_SRR    = 1;
  localparam int W0_IDE    = 0;
  localparam int W1_EID_H  = 11;
  localparam int W1_EID_L  = 0;
  localparam int W2_EID_H  = 15;
  localparam int W2_EID_L  = 10;
  localparam int W2_RTR    = 9;
  localparam int W2_DLC_H  = 3;
  localparam int W2_DLC_L  = 0;
  localparam int W7_FILT_L = 8;
endpackage

//--- rtl/cbsl_buffer_ctrl.sv
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// R1 - buffer store sets its full flag; software clears by writing zero only
// R2 - store into a full buffer sets its overflow flag until written zero
// R3 - each control register: low byte even buffer, high byte next odd buffer
// R4 - direction bit 1 makes transmit buffer, 0 makes receive buffer
// R5 - aborted bit reads 1 after abort, 0 after successful send
// R6 - lost-arbitration bit set when the message loses arbitration
// R7 - transmit-error bit set when a bus error hits the message
// R8 - setting send request clears aborted, lost-arbitration and error bits
// R9 - send request queues message; cleared by hardware after success
// R10 - software clearing a set send request asks for an abort
// R11 - matching remote frame sets send request only when auto reply enabled
// R12 - two-bit priority, 11 highest down to 00, picks next message
// R13 - software writes message buffers directly into DMA RAM it places
// R14 - word 0: identifier bits 12-2, SRR bit 1, IDE bit 0, top zero
// R15 - software sets SRR for remote standard frames; 1 for extended
// R16 - IDE 1 sends extended identifier, 0 sends standard identifier
// R17 - extended id 17-6 in word 1 bits 11-0, 5-0 in word 2 15-10
// R18 - RTR word 2 bit 9 selects remote only for extended frames
// R19 - software writes zero into reserved bits 8 and 4 of word 2
// R20 - data length code in word 2 bits 3-0, bits 7-5 unused
// R21 - data bytes in words 3-6, even byte low, odd byte high
// R22 - receive store writes matched filter number to word 7 bits 12-8
module cbsl_buffer_ctrl
  import cbsl_pkg::*;
(
  input  logic        ref_clk,
  input  logic        rst,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  input  logic        rxStore,
  input  logic [4:0]  rxBufIdx,
  input  logic [4:0]  rxFilterHit,
  input  logic        rtrMatch,
  input  logic [2:0]  rtrBufIdx,
  input  logic        txDone,
  input  logic        txLostArb,
  input  logic        txBusErr,
  input  logic        txAbortDone,
  input  logic [2:0]  txBufIdx,
  input  logic [15:0] frmWord0,
  input  logic [15:0] frmWord1,
  input  logic [15:0] frmWord2,
  input  logic [15:0] frmDataWord,
  input  logic        frmByteOdd,
  output logic        dmaWe,
  output logic [4:0]  dmaBufIdx,
  output logic [15:0] dmaWordData,
  output logic        txPending,
  output logic [2:0]  txSelIdx,
  output logic [7:0]  txAbortReq,
  output logic        txIdExt,
  output logic [28:0] txId,
  output logic        txRemote,
  output logic [3:0]  txDlc,
  output logic [7:0]  txByte
);

  logic        wbReq;
  logic        wbTake;
  logic        wbWr;
  logic [15:0] wMask;
  logic [15:0] wDat;
  logic        wrFullLo;
  logic        wrFullHi;
  logic        wrOvfLo;
  logic        wrOvfHi;
  logic [3:0]  wrCon;
  logic [31:0] clrFull;
  logic [31:0] clrOvf;
  logic        rxIsTx;
  logic        rxOk;
  logic [31:0] rxFull_r;
  logic [31:0] rx_overflow_flags_r;
  logic [7:0]  trCon_r [NTX];
  logic [7:0]  conNxt  [NTX];
  logic [7:0]  abort_r;
  logic [7:0]  abortNxt;
  logic [7:0]  conWrK;
  logic        selValid;
  logic [2:0]  selIdx;
  logic [1:0]  selPri;
  logic [15:0] rdData;
  logic        wbAck_r;
  logic [31:0] wbDat_r;

  assign wbReq  = wb_cyc_i & wb_stb_i;
  assign wbTake = wbReq & ~wbAck_r;
  assign wbWr   = wbTake & wb_we_i;
  assign wMask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wDat   = wb_dat_i[15:0];

  assign wrFullLo = wbWr & (wb_adr_i == OFS_FULL_LO);
  assign wrFullHi = wbWr & (wb_adr_i == OFS_FULL_HI);
  assign wrOvfLo  = wbWr & (wb_adr_i == OFS_OVF_LO);
  assign wrOvfHi  = wbWr & (wb_adr_i == OFS_OVF_HI);
  assign wrCon[0] = wbWr & (wb_adr_i == OFS_CON0);
  assign wrCon[1] = wbWr & (wb_adr_i == OFS_CON1);
  assign wrCon[2] = wbWr & (wb_adr_i == OFS_CON2);
  assign wrCon[3] = wbWr & (wb_adr_i == OFS_CON3);

  // a one written never sets a flag, only zeros in enabled lanes clear
  assign clrFull = {{16{wrFullHi}} & wMask & ~wDat, {16{wrFullLo}} & wMask & ~wDat}; // see R1
  assign clrOvf  = {{16{wrOvfHi}} & wMask & ~wDat, {16{wrOvfLo}} & wMask & ~wDat}; // see R2

  // stores aimed at a transmit buffer are dropped
  assign rxIsTx = (rxBufIdx < 5'(NTX)) && trCon_r[rxBufIdx[2:0]][CON_DIR]; // see R4
  assign rxOk   = rxStore & ~rxIsTx;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rxFull_r <= {RST_FLAGS, RST_FLAGS};
    else
    begin
      rxFull_r <= rxFull_r & ~clrFull;
      // set wins over a clear in the same cycle only for an empty flag; a full flag clears
      if (rxOk && !rxFull_r[rxBufIdx])
        rxFull_r[rxBufIdx] <= 1'b1; // see R1
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rx_overflow_flags_r <= {RST_FLAGS, RST_FLAGS};
    else
    begin
      rx_overflow_flags_r <= rx_overflow_flags_r & ~clrOvf;
      // judged on the flag before any clear this cycle
      if (rxOk && rxFull_r[rxBufIdx])
        rx_overflow_flags_r[rxBufIdx] <= 1'b1; // see R2
    end
  end

  // filter hit lands in word 7; a full buffer is not overwritten
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dmaWe       <= 1'b0;
      dmaBufIdx   <= 5'h00;
      dmaWordData <= 16'h0000;
    end
    else
    begin
      dmaWe <= rxOk & ~rxFull_r[rxBufIdx];
      if (rxOk)
      begin
        dmaBufIdx   <= rxBufIdx;
        dmaWordData <= {3'h0, rxFilterHit, 8'h00}; // see R22
      end
    end
  end

  always_comb
  begin
    for (int k = 0; k < NTX; k++)
      conWrK[k] = wrCon[k / 2] & wb_sel_i[k % 2]; // see R3
  end

  always_comb
  begin
    logic [7:0] cur;
    logic [7:0] wv;
    logic       mine;
    logic       reqRise;
    logic       swAbort;
    cur     = 8'h00;
    wv      = 8'h00;
    mine    = 1'b0;
    reqRise = 1'b0;
    swAbort = 1'b0;
    for (int k = 0; k < NTX; k++)
    begin
      cur     = trCon_r[k];
      wv      = (k % 2 == 1) ? wDat[15:8] : wDat[7:0]; // see R3
      mine    = (txBufIdx == 3'(k));
      reqRise = 1'b0;
      swAbort = 1'b0;
      conNxt[k] = cur;
      if (conWrK[k])
      begin
        conNxt[k][CON_DIR]   = wv[CON_DIR]; // see R4
        conNxt[k][CON_RTREN] = wv[CON_RTREN];
        conNxt[k][CON_PRI_H:CON_PRI_L] = wv[CON_PRI_H:CON_PRI_L];
        if (wv[CON_REQ] && !cur[CON_REQ])
          reqRise = 1'b1; // see R9
        else if (!wv[CON_REQ] && cur[CON_REQ])
        begin
          conNxt[k][CON_REQ] = 1'b0;
          swAbort = 1'b1; // see R10
        end
      end
      if (mine && txLostArb)
        conNxt[k][CON_LARB] = 1'b1; // see R6
      if (mine && txBusErr)
        conNxt[k][CON_ERR] = 1'b1; // see R7
      if (mine && txDone)
      begin
        conNxt[k][CON_REQ] = 1'b0; // see R9
        conNxt[k][CON_ABT] = 1'b0; // see R5
      end
      if (mine && txAbortDone)
        conNxt[k][CON_ABT] = 1'b1; // see R5
      // auto reply only for a transmit buffer with reply enabled
      if (rtrMatch && rtrBufIdx == 3'(k) && cur[CON_RTREN] && cur[CON_DIR])
        reqRise = 1'b1; // see R11
      if (reqRise)
      begin
        conNxt[k][CON_REQ]  = 1'b1;
        conNxt[k][CON_ABT]  = 1'b0; // see R8
        conNxt[k][CON_LARB] = 1'b0; // see R8
        conNxt[k][CON_ERR]  = 1'b0; // see R8
      end
      // abort stays asked until the engine reports an outcome or a new send request is set
      abortNxt[k] = (abort_r[k] | swAbort) & ~(mine & (txAbortDone | txDone)) & ~reqRise;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < NTX; k++)
        trCon_r[k] <= RST_CON;
      abort_r <= 8'h00;
    end
    else
    begin
      for (int k = 0; k < NTX; k++)
        trCon_r[k] <= conNxt[k];
      abort_r <= abortNxt;
    end
  end

  // ties go to the lowest buffer number
  always_comb
  begin
    selValid = 1'b0;
    selIdx   = 3'h0;
    selPri   = 2'h0;
    for (int k = 0; k < NTX; k++)
    begin
      if (trCon_r[k][CON_DIR] && trCon_r[k][CON_REQ] && !abort_r[k])
      begin
        if (!selValid || trCon_r[k][CON_PRI_H:CON_PRI_L] > selPri) // see R12
        begin
          selValid = 1'b1;
          selIdx   = 3'(k);
          selPri   = trCon_r[k][CON_PRI_H:CON_PRI_L];
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txPending  <= 1'b0;
      txSelIdx   <= 3'h0;
      txAbortReq <= 8'h00;
    end
    else
    begin
      txPending  <= selValid;
      txSelIdx   <= selIdx; // see R12
      txAbortReq <= abortNxt; // see R10
    end
  end

  // frame fields from the chosen buffer words; reserved bits ignored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txIdExt  <= 1'b0;
      txId     <= 29'h0;
      txRemote <= 1'b0;
      txDlc    <= 4'h0;
      txByte   <= 8'h00;
    end
    else
    begin
      txIdExt <= frmWord0[W0_IDE]; // see R16
      if (frmWord0[W0_IDE])
        txId <= {frmWord0[W0_SID_H:W0_SID_L], frmWord1[W1_EID_H:W1_EID_L],
                 frmWord2[W2_EID_H:W2_EID_L]}; // see R17
      else
        txId <= {18'h0, frmWord0[W0_SID_H:W0_SID_L]}; // see R14
      // RTR counts only for extended frames
      txRemote <= frmWord0[W0_IDE] ? frmWord2[W2_RTR] : frmWord0[W0_SRR]; // see R18
      txDlc    <= frmWord2[W2_DLC_H:W2_DLC_L]; // see R20
      txByte   <= frmByteOdd ? frmDataWord[15:8] : frmDataWord[7:0]; // see R21
    end
  end

  always_comb
  begin
    rdData = 16'h0000;
    case (wb_adr_i)
      OFS_FULL_LO: rdData = rxFull_r[15:0];
      OFS_FULL_HI: rdData = rxFull_r[31:16];
      OFS_OVF_LO:  rdData = rx_overflow_flags_r[15:0];
      OFS_OVF_HI:  rdData = rx_overflow_flags_r[31:16];
      OFS_CON0:    rdData = {trCon_r[1], trCon_r[0]}; // see R3
      OFS_CON1:    rdData = {trCon_r[3], trCon_r[2]};
      OFS_CON2:    rdData = {trCon_r[5], trCon_r[4]};
      OFS_CON3:    rdData = {trCon_r[7], trCon_r[6]};
      default:     rdData = 16'h0000;
    endcase
  end

  // unmapped addresses still ack, read zero, ignore writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wbAck_r <= 1'b0;
      wbDat_r <= 32'h0;
    end
    else
    begin
      wbAck_r <= wbTake;
      wbDat_r <= {16'h0000, rdData};
    end
  end

  assign wb_ack_o = wbAck_r;
  assign wb_dat_o = wbDat_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_full_set: assert property (rxOk && !rxFull_r[rxBufIdx] |=> rxFull_r[$past(rxBufIdx)]) // see R1
    else $error("full flag not set by store");
  a_one_no_set: assert property (wrFullLo && wb_sel_i[0] && wDat[0] && !rxFull_r[0]
    && !(rxOk && rxBufIdx == 5'h00) |=> !rxFull_r[0]) // see R1
    else $error("writing one set full flag");
  a_ovf_set: assert property (rxOk && rxFull_r[rxBufIdx]
    |=> rx_overflow_flags_r[$past(rxBufIdx)] && !dmaWe) // see R2
    else $error("overflow not flagged");
  a_req_clr_stat: assert property ($rose(trCon_r[1][CON_REQ])
    |-> trCon_r[1][CON_ABT:CON_ERR] == 3'h0) // see R8
    else $error("status not cleared on request");
  a_done_clr_req: assert property (txDone && txBufIdx == 3'h1 && !conWrK[1]
    && !(rtrMatch && rtrBufIdx == 3'h1) |=> !trCon_r[1][CON_REQ] && !trCon_r[1][CON_ABT]) // see R9
    else $error("request not cleared after send");
  a_abort_ask: assert property (conWrK[1] && !wDat[8 + CON_REQ] && trCon_r[1][CON_REQ]
    && !(txBufIdx == 3'h1 && (txDone || txAbortDone)) && !(rtrMatch && rtrBufIdx == 3'h1)
    |=> txAbortReq[1] && !trCon_r[1][CON_REQ]) // see R10
    else $error("abort not requested");
  a_rtr_reply: assert property (rtrMatch && rtrBufIdx == 3'h2 && trCon_r[2][CON_RTREN]
    && trCon_r[2][CON_DIR] |=> trCon_r[2][CON_REQ]) // see R11
    else $error("remote reply not queued");
  a_rtr_off: assert property (rtrMatch && rtrBufIdx == 3'h3 && !trCon_r[3][CON_RTREN]
    && !conWrK[3] && !(txBufIdx == 3'h3 && txDone) |=> $stable(trCon_r[3][CON_REQ])) // see R11
    else $error("request changed with reply off");
  a_pri_pick: assert property (selValid |=> txPending && txSelIdx == $past(selIdx)
    && $past(trCon_r[selIdx][CON_PRI_H:CON_PRI_L]) >= $past(trCon_r[0][CON_PRI_H:CON_PRI_L])
    || !$past(trCon_r[0][CON_REQ] && trCon_r[0][CON_DIR]) || $past(abort_r[0])) // see R12
    else $error("lower priority picked");
  a_ext_id: assert property (frmWord0[W0_IDE] |=> txIdExt
    && txId[17:0] == {$past(frmWord1[11:0]), $past(frmWord2[15:10])}) // see R17
    else $error("extended id misplaced");
  a_std_frame: assert property (!frmWord0[W0_IDE] |=> !txIdExt && txId[28:11] == 18'h0
    && txRemote == $past(frmWord0[W0_SRR])) // see R18
    else $error("standard frame decode wrong");
  a_filt_word: assert property (rxOk && !rxFull_r[rxBufIdx] |=> dmaWe
    && dmaWordData[12:8] == $past(rxFilterHit) && dmaWordData[7:0] == 8'h00) // see R22
    else $error("filter hit word wrong");
  a_wb_ack: assert property (wbReq && !wbAck_r |=> wbAck_r ##1 !wbAck_r)
    else $error("ack not one cycle");

  c_overflow: cover property (rxOk && rxFull_r[rxBufIdx]);
  c_abort: cover property ($rose(txAbortReq[1]) ##[1:20] trCon_r[1][CON_ABT]);
  c_rtr: cover property (rtrMatch && trCon_r[rtrBufIdx][CON_RTREN] && trCon_r[rtrBufIdx][CON_DIR]);
  c_pri: cover property (txPending && txSelIdx != 3'h0 && trCon_r[0][CON_REQ]);

endmodule

//--- bench/cbsl_can_node.sv
`timescale 1ns/100ps
module cbsl_can_node
(
  input  logic        ref_clk,
  output logic        rxStore,
  output logic [4:0]  rxBufIdx,
  output logic [4:0]  rxFilterHit,
  output logic [4:0]  txEvt,
  output logic [2:0]  evIdx,
  output logic [15:0] frmWord0,
  output logic [15:0] frmWord1,
  output logic [15:0] frmWord2,
  output logic [15:0] frmDataWord,
  output logic        frmByteOdd
);
  initial
  begin
    rxStore = 1'b0;
    rxBufIdx = 5'h00;
    rxFilterHit = 5'h00;
    txEvt = 5'h00;
    evIdx = 3'h0;
    {frmWord0, frmWord1, frmWord2, frmDataWord, frmByteOdd} = '0;
  end
  // released index lines flip, so a stale index never looks live
  task automatic rx(input logic [4:0] b, input logic [4:0] h);
    @(posedge ref_clk);
    rxStore <= 1'b1;
    rxBufIdx <= b;
    rxFilterHit <= h;
    @(posedge ref_clk);
    rxStore <= 1'b0;
    rxBufIdx <= ~b;
    rxFilterHit <= ~h;
  endtask
  // k: 0 sent, 1 lost arbitration, 2 bus error, 3 abort done, 4 remote frame
  task automatic ev(input int k, input logic [2:0] b);
    @(posedge ref_clk);
    txEvt <= 5'h01 << k;
    evIdx <= b;
    @(posedge ref_clk);
    txEvt <= 5'h00;
    evIdx <= ~b;
  endtask
  // buffer words as software laid them in ram; std frames get a wrong rtr bit
  task automatic frm(input logic e, input logic [10:0] sid, input logic [17:0] eid,
                     input logic rm, input logic [3:0] dlc, input logic [15:0] dw);
    @(posedge ref_clk);
    frmWord0 <= {3'h0, sid, e | rm, e};
    frmWord1 <= {4'h0, eid[17:6]};
    frmWord2 <= {eid[5:0], e ? rm : ~rm, 1'b0, 3'h0, 1'b0, dlc};
    frmDataWord <= dw;
    frmByteOdd <= dw[0];
  endtask
endmodule

//--- bench/cbsl_buffer_ctrl_tb.sv
`timescale 1ns/100ps
module cbsl_buffer_ctrl_tb;
  import cbsl_pkg::*;
  logic        ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rxStore, frmByteOdd;
  logic        dmaWe, txPending, txIdExt, txRemote;
  logic [7:0]  wb_adr_i, txAbortReq, txByte;
  logic [3:0]  wb_sel_i, txDlc;
  logic [31:0] wb_dat_i, wb_dat_o, seed, rd, full, ovf;
  logic [4:0]  rxBufIdx, rxFilterHit, txEvt, dmaBufIdx;
  logic [2:0]  evIdx, txSelIdx;
  logic [15:0] frmWord0, frmWord1, frmWord2, frmDataWord, dmaWordData;
  logic [28:0] txId;
  logic [7:0]  con [8];
  int          fails, n_tests;

  cbsl_buffer_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxStore(rxStore),
    .rxBufIdx(rxBufIdx), .rxFilterHit(rxFilterHit), .rtrMatch(txEvt[4]),
    .rtrBufIdx(evIdx), .txDone(txEvt[0]), .txLostArb(txEvt[1]), .txBusErr(txEvt[2]),
    .txAbortDone(txEvt[3]), .txBufIdx(evIdx), .frmWord0(frmWord0), .frmWord1(frmWord1),
    .frmWord2(frmWord2), .frmDataWord(frmDataWord), .frmByteOdd(frmByteOdd),
    .dmaWe(dmaWe), .dmaBufIdx(dmaBufIdx), .dmaWordData(dmaWordData),
    .txPending(txPending), .txSelIdx(txSelIdx), .txAbortReq(txAbortReq),
    .txIdExt(txIdExt), .txId(txId), .txRemote(txRemote), .txDlc(txDlc), .txByte(txByte));
  cbsl_can_node node_u (.ref_clk(ref_clk), .rxStore(rxStore), .rxBufIdx(rxBufIdx),
    .rxFilterHit(rxFilterHit), .txEvt(txEvt), .evIdx(evIdx), .frmWord0(frmWord0),
    .frmWord1(frmWord1), .frmWord2(frmWord2), .frmDataWord(frmDataWord),
    .frmByteOdd(frmByteOdd));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // waits on ack, the watchdog ends a hang; the answer is taken only at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= {seed[1:0], 2'b11};
    for (n = 0; wb_ack_o !== 1'b1; n++)
      @(posedge ref_clk);
    // ack one cycle after the take edge, seen at the second edge
    chk(32'(n), 32'd2);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, seed);
    chk(rd, e);
  endtask

  function automatic logic [7:0] swcon(input logic [7:0] o, input logic [7:0] n);
    logic [7:0] r;
    r = {n[7], o[6:3], n[2:0]};
    if (n[3] && !o[3])
      r[6:3] = 4'h1;
    if (!n[3] && o[3])
      r[3] = 1'b0;
    return r;
  endfunction

  function automatic int pick();
    int s;
    s = -1;
    for (int b = 0; b < 8; b++)
      if (con[b][7] && con[b][3] && (s < 0 || con[b][1:0] > con[s][1:0]))
        s = b;
    return s;
  endfunction

  task automatic sweep();
    int s;
    rdc(OFS_FULL_LO, {16'h0, full[15:0]});
    rdc(OFS_FULL_HI, {16'h0, full[31:16]});
    rdc(OFS_OVF_LO, {16'h0, ovf[15:0]});
    rdc(OFS_OVF_HI, {16'h0, ovf[31:16]});
    for (int p = 0; p < 4; p++)
      rdc(OFS_CON0 + 8'(4 * p), {16'h0, con[2*p+1], con[2*p]});
    rdc(8'h20 + 8'(seed[3:0]), 32'h0);
    s = pick();
    chk(32'(txPending), 32'(s >= 0));
    if (s >= 0)
      chk(32'(txSelIdx), 32'(s));
  endtask

  task automatic wcon(input int p, input logic [7:0] lo, input logic [7:0] hi);
    bus(1'b1, OFS_CON0 + 8'(4 * p), {16'h0, hi, lo});
    con[2*p] = swcon(con[2*p], lo);
    con[2*p+1] = swcon(con[2*p+1], hi);
  endtask

  task automatic trx(input logic [4:0] b, input logic [4:0] h);
    logic ok;
    ok = !(b < 8 && con[b[2:0]][7]);
    node_u.rx(b, h);
    #1;
    chk(32'(dmaWe), 32'(ok && !full[b]));
    if (ok && !full[b])
      chk({dmaBufIdx, dmaWordData}, {b, 3'h0, h, 8'h00});
    ovf[b] = ovf[b] | (ok & full[b]);
    full[b] = full[b] | ok;
  endtask

  task automatic tev(input int k, input logic [2:0] b);
    node_u.ev(k, b);
    case (k)
      0: con[b] = con[b] & 8'hb7;
      1: con[b][5] = 1'b1;
      2: con[b][4] = 1'b1;
      3: con[b][6] = 1'b1;
      default:
        if (con[b][7] && con[b][2] && !con[b][3])
          con[b] = swcon(con[b], con[b] | 8'h08);
    endcase
  endtask

  initial
  begin
    #(50 * 6000);
    fails++;
    close_out();
  end

  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {seed, full, ovf, fails, n_tests} = {32'd85566, 128'h0};
    for (int b = 0; b < 8; b++)
      con[b] = 8'h00;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    sweep();
    $display("test done: reset values");
    wcon(0, 8'hf9, 8'h8b);
    trx(5'd0, 5'd3);
    trx(5'd2, 5'd7);
    trx(5'd2, 5'd9);
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      trx(5'(8 + 3 * seed[2:0]), seed[8:4]);
    end
    bus(1'b1, OFS_FULL_HI, 32'h0000ffff);
    bus(1'b1, OFS_FULL_HI, {16'h0, seed[15:0]});
    full[31:16] = full[31:16] & seed[15:0];
    bus(1'b1, OFS_OVF_HI, {16'h0, seed[31:16]});
    ovf[31:16] = ovf[31:16] & seed[31:16];
    bus(1'b1, OFS_FULL_LO, 32'h0000fffb);
    full[2] = 1'b0;
    bus(1'b1, 8'h24, 32'hffffffff);
    trx(5'd2, 5'd5);
    sweep();
    $display("test done: receive flags");
    tev(1, 3'd1);
    tev(2, 3'd1);
    sweep();
    wcon(0, 8'h89, 8'h83);
    #1;
    chk(32'(txAbortReq), 32'h02);
    tev(3, 3'd1);
    #1;
    chk(32'(txAbortReq), 32'h00);
    sweep();
    wcon(0, 8'h89, 8'h8b);
    sweep();
    tev(0, 3'd1);
    sweep();
    wcon(1, 8'h84, 8'h80);
    tev(4, 3'd2);
    tev(4, 3'd3);
    sweep();
    $display("test done: send control");
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wcon(2, 8'h88 | seed[1:0], 8'h88 | seed[3:2]);
      wcon(3, 8'h88 | seed[5:4], 8'h88 | seed[7:6]);
      sweep();
    end
    $display("test done: priority");
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      node_u.frm(seed[0], seed[11:1], seed[29:12], seed[30], seed[4:1], seed[31:16]);
      @(posedge ref_clk);
      #1;
      chk({txIdExt, txId}, {seed[0], seed[0] ? {seed[11:1], seed[29:12]}
          : {18'h0, seed[11:1]}});
      chk({txRemote, txDlc, txByte}, {seed[30], seed[4:1],
          seed[16] ? seed[31:24] : seed[23:16]});
    end
    $display("test done: frame decode");
    close_out();
  end
endmodule
